// ---- common/ast_defines.vh ----
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH
// Printed offsets are register indices; byte address is four times
`define AST_IDX_TIMING     12'hf78
`define AST_IDX_UPHI       12'hf79
`define AST_IDX_UPLO       12'hf7a
`define AST_IDX_CTRL       12'hf7d
`define AST_IDX_STATUS     12'hf7e
`define AST_IDX_IRQ_EN     12'hf7f
`define AST_IDX_IRQ_CLR    12'hf80
`define AST_RST_TIMING     8'h00
`define AST_RST_UPHI       8'hff
`define AST_RST_UPLO       8'hff
`define AST_START_CONVERT  2'h1
`define AST_CTRL_START_LSB 0
`define AST_CTRL_RES_BIT   2
`define AST_CTRL_MODE_LSB  3
`define AST_ST_OVER_BIT    0
`define AST_ST_DONE_BIT    1
`define AST_ST_BUSY_BIT    2
`define AST_RESP_OKAY      2'h0
`define AST_RESP_SLVERR    2'h2
`endif

// ---- design/ast_sample_timer.v ----
// Functional notes
// R1: Conversion start by control start code 01 or event trigger runs sampling.
// R2: Sampling field bits 7:4 selects 2,2,4,8..1024 ADC clocks.
// R3: Input config 00/01 gives settling of one clock, field ignored.
// R4: Input config 10/11 gives settling of code plus one clocks.
// R5: Interrupt when unsigned result exceeds upper threshold.
// R6: 12-bit compares top 4 result bits with high byte bits 3:0.
// R7: 14-bit compares top 6 result bits with high byte bits 5:0.
// R8: Low result byte compares with all of low threshold byte.
// R9: Software programs enough sampling clocks for its source.
// R10: Precision select 0 means 12-bit, 1 means 14-bit.
// R11: Compare once per completed conversion with current thresholds.
`include "ast_defines.vh"
`default_nettype none
module ast_sample_timer (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // AXI4-Lite write
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Converter core
  input  wire        eventTrig,
  input  wire        convDone,
  input  wire [13:0] convResult,
  output reg         samplePhase,
  output reg         settlePhase,
  output reg         sampleDone,
  // Interrupt
  output reg         irq
);

  localparam [2:0] S_IDLE   = 3'b001;
  localparam [2:0] S_SAMPLE = 3'b010;
  localparam [2:0] S_SETTLE = 3'b100;

  reg [7:0]  sampleTiming;
  reg [7:0]  upperLimitHigh;
  reg [7:0]  upperLimitLow;
  reg [1:0]  inputConfig;
  reg        precisionSelect;
  reg [1:0]  irqStatus;
  reg [1:0]  irqEnable;
  reg [2:0]  state;
  reg [10:0] count;
  reg [15:0] awAddr;
  reg        awHeld;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  reg        wHeld;

  function [10:0] sampleClocks;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1: sampleClocks = 11'd2;
        4'h2: sampleClocks = 11'd4;
        4'h3: sampleClocks = 11'd8;
        4'h4: sampleClocks = 11'd16;
        4'h5: sampleClocks = 11'd32;
        4'h6: sampleClocks = 11'd64;
        4'h7: sampleClocks = 11'd96;
        4'h8: sampleClocks = 11'd128;
        4'h9: sampleClocks = 11'd192;
        4'ha: sampleClocks = 11'd256;
        4'hb: sampleClocks = 11'd320;
        4'hc: sampleClocks = 11'd384;
        4'hd: sampleClocks = 11'd512;
        4'he: sampleClocks = 11'd768;
        default: sampleClocks = 11'd1024;
      endcase
    end
  endfunction

  // Word index from byte address, valid only when aligned
  function [12:0] regIndex;
    input [15:0] addr;
    begin
      regIndex = (addr[1:0] == 2'b00) ? {1'b0, addr[13:2]} : 13'h1fff;
    end
  endfunction

  wire [3:0] settleCode = sampleTiming[3:0];
  wire [10:0] settleClocks = inputConfig[1] ?
      {7'd0, settleCode} + 11'd1 : 11'd1; // R3 R4

  // Threshold alignment by precision
  wire [13:0] upperLimit = precisionSelect ?
      {upperLimitHigh[5:0], upperLimitLow} : // R7 R8 R10
      {2'b00, upperLimitHigh[3:0], upperLimitLow}; // R6 R8
  wire [13:0] resultAligned = precisionSelect ?
      convResult : {2'b00, convResult[11:0]}; // R10
  wire overLimit = convDone && (resultAligned > upperLimit); // R5 R11

  wire writeGo = awHeld && wHeld && !s_axi_bvalid;
  wire [12:0] wIdx = regIndex(awAddr);
  wire [1:0] startCode = wData[`AST_CTRL_START_LSB +: 2];
  wire ctrlWrite = writeGo && wIdx == {1'b0, `AST_IDX_CTRL} && wStrb[0];
  wire startReq = (ctrlWrite && startCode == `AST_START_CONVERT)
      || eventTrig; // R1
  wire clrWrite = writeGo && wIdx == {1'b0, `AST_IDX_IRQ_CLR} && wStrb[0];
  wire [1:0] clrBits = clrWrite ? wData[1:0] : 2'b00;
  wire settleEnd = state == S_SETTLE && count == 11'd1;
  wire [1:0] events = {settleEnd, overLimit};
  wire [1:0] next_irqStatus = (irqStatus & ~clrBits) | events;

  // Conversion timing sequencer
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      count <= 11'd0;
      samplePhase <= 1'b0;
      settlePhase <= 1'b0;
      sampleDone <= 1'b0;
    end else begin
      sampleDone <= 1'b0;
      case (state)
        S_IDLE: begin
          if (startReq) begin // R1
            state <= S_SAMPLE;
            count <= sampleClocks(sampleTiming[7:4]); // R2
            samplePhase <= 1'b1;
          end
        end
        S_SAMPLE: begin
          if (count == 11'd1) begin
            state <= S_SETTLE;
            count <= settleClocks; // R3 R4
            samplePhase <= 1'b0;
            settlePhase <= 1'b1;
          end else begin
            count <= count - 11'd1;
          end
        end
        S_SETTLE: begin
          if (count == 11'd1) begin
            state <= S_IDLE;
            settlePhase <= 1'b0;
            sampleDone <= 1'b1;
          end else begin
            count <= count - 11'd1;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Register writes and interrupt status
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleTiming <= `AST_RST_TIMING;
      upperLimitHigh <= `AST_RST_UPHI;
      upperLimitLow <= `AST_RST_UPLO;
      inputConfig <= 2'b00;
      precisionSelect <= 1'b0;
      irqStatus <= 2'b00;
      irqEnable <= 2'b00;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus; // R5
      irq <= |(next_irqStatus & irqEnable); // R5
      if (writeGo && wStrb[0]) begin
        case (wIdx)
          {1'b0, `AST_IDX_TIMING}: sampleTiming <= wData[7:0];
          {1'b0, `AST_IDX_UPHI}: upperLimitHigh <= wData[7:0];
          {1'b0, `AST_IDX_UPLO}: upperLimitLow <= wData[7:0];
          {1'b0, `AST_IDX_CTRL}: begin
            precisionSelect <= wData[`AST_CTRL_RES_BIT]; // R10
            inputConfig <= wData[`AST_CTRL_MODE_LSB +: 2];
          end
          {1'b0, `AST_IDX_IRQ_EN}: irqEnable <= wData[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // AXI write channel
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AST_RESP_OKAY;
      awAddr <= 16'h0000;
      awHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      wHeld <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (writeGo) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (wIdx)
          {1'b0, `AST_IDX_TIMING}, {1'b0, `AST_IDX_UPHI},
          {1'b0, `AST_IDX_UPLO}, {1'b0, `AST_IDX_CTRL},
          {1'b0, `AST_IDX_IRQ_EN}, {1'b0, `AST_IDX_IRQ_CLR}:
            s_axi_bresp <= `AST_RESP_OKAY;
          default: s_axi_bresp <= `AST_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI read channel
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AST_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `AST_RESP_OKAY;
        case (regIndex(s_axi_araddr))
          {1'b0, `AST_IDX_TIMING}: s_axi_rdata <= {24'h0, sampleTiming};
          {1'b0, `AST_IDX_UPHI}: s_axi_rdata <= {24'h0, upperLimitHigh};
          {1'b0, `AST_IDX_UPLO}: s_axi_rdata <= {24'h0, upperLimitLow};
          {1'b0, `AST_IDX_CTRL}:
            s_axi_rdata <= {27'h0, inputConfig, precisionSelect, 2'b00};
          {1'b0, `AST_IDX_STATUS}:
            s_axi_rdata <= {29'h0, state != S_IDLE, irqStatus};
          {1'b0, `AST_IDX_IRQ_EN}: s_axi_rdata <= {30'h0, irqEnable};
          {1'b0, `AST_IDX_IRQ_CLR}: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AST_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ast_sample_timer
`default_nettype wire

// ---- testbench/ast_sample_timer_checker.sv ----
`default_nettype none
module ast_sample_timer_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic eventTrig,
  input wire logic samplePhase,
  input wire logic settlePhase,
  input wire logic sampleDone
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Cycles spent sampling so far; too long for a delay range
  logic [10:0] sampleRun;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleRun <= 11'h000;
    end else begin
      sampleRun <= samplePhase ? sampleRun + 11'h001 : 11'h000;
    end
  end
  sequence sIdle;
    !samplePhase && !settlePhase && !sampleDone;
  endsequence
  AST_START: assert property (eventTrig ##0 sIdle |=> samplePhase)
    else $error("no sampling");
  AST_EXCL: assert property (!(samplePhase && settlePhase))
    else $error("overlap");
  AST_MIN: assert property ($rose(samplePhase) |=> samplePhase)
    else $error("short sampling");
  AST_MAX: assert property (
    samplePhase |-> sampleRun < 11'h400) else $error("long");
  AST_SETTLE: assert property ($fell(samplePhase) |-> settlePhase)
    else $error("no settling");
  AST_SMAX: assert property (
    $rose(settlePhase) |-> ##[1:16] !settlePhase) else $error("long");
  AST_DONE: assert property ($fell(settlePhase) |-> sampleDone)
    else $error("no done");
  AST_PULSE: assert property (sampleDone |=> !sampleDone)
    else $error("done stuck");
endmodule // ast_sample_timer_checker
bind ast_sample_timer ast_sample_timer_checker chk (.*);
`default_nettype wire

// ---- testbench/ast_conv_core_model.sv ----
`default_nettype none
module ast_conv_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Sequencer side
  input wire logic sampleDone,
  input wire logic [13:0] nextResult,
  output var logic convDone,
  output var logic [13:0] convResult
);
  timeunit 1ns;
  timeprecision 1ps;
  // Result toggles when not valid
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      convDone <= 1'b0;
      convResult <= 14'h0;
    end else begin
      convDone <= sampleDone;
      convResult <= sampleDone ? nextResult : ~convResult;
    end
  end
endmodule // ast_conv_core_model
`default_nettype wire

// ---- testbench/ast_sample_timer_bench.sv ----
`include "ast_defines.vh"
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module ast_sample_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, arst_n = 0, eventTrig = 0, s_axi_awvalid = 0;
  logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, p, en, over;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0, rnd = 16'h2d;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [13:0] nextResult = 0, t, r;
  logic [7:0] hi;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, convDone, samplePhase, settlePhase;
  wire logic sampleDone, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [13:0] convResult;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, sCnt = 0, tCnt = 0;
  int es, em, lenQ[$];
  logic [17:0] q, rdQ[$];
  logic [1:0] br, wrQ[$];
  int per[16] = '{2, 2, 4, 8, 16, 32, 64, 96, 128, 192, 256, 320, 384,
    512, 768, 1024};
  ast_sample_timer dut (.*);
  ast_conv_core_model core (.*);
  always #5 ref_clk = ~ref_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    bit a = 1, w = 1;
    wrQ.push_back(`AST_RESP_OKAY);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (a || w) begin
      @(posedge ref_clk);
      if (s_axi_awready) a = 0;
      if (s_axi_wready) w = 0;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] m, e);
    // Indices below the register block are unmapped
    rdQ.push_back({idx < `AST_IDX_TIMING ? `AST_RESP_SLVERR
      : `AST_RESP_OKAY, m, e});
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge ref_clk);
  endtask
  // Zero start code means start by event
  task automatic go(input logic [7:0] tm, c, input int s, m);
    lenQ.push_back(s);
    lenQ.push_back(m);
    wr(`AST_IDX_TIMING, tm);
    wr(`AST_IDX_CTRL, c);
    if (c[1:0] == 2'b00) begin
      eventTrig <= 1;
      @(posedge ref_clk);
      eventTrig <= 0;
    end
    @(negedge sampleDone);
    repeat (3) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      q = rdQ.pop_front();
      `CHK("rdata", {24'h0, q[7:0]}, s_axi_rdata & {24'hffffff, q[15:8]})
      `CHK("rresp", q[17:16], s_axi_rresp)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      br = wrQ.pop_front();
      `CHK("bresp", br, s_axi_bresp)
    end
    if (samplePhase) sCnt++;
    if (settlePhase) tCnt++;
    if (sampleDone) begin
      es = lenQ.pop_front();
      em = lenQ.pop_front();
      `CHK("sample", es, sCnt)
      `CHK("settle", em, tCnt)
      sCnt = 0;
      tCnt = 0;
    end
    if (++cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    rd(`AST_IDX_TIMING, 8'hff, `AST_RST_TIMING);
    rd(`AST_IDX_UPHI, 8'hff, `AST_RST_UPHI);
    rd(`AST_IDX_UPLO, 8'hff, `AST_RST_UPLO);
    rd(12'h100, 8'hff, 8'h00);
    for (int i = 0; i < 16; i++)
      go({i[3:0], i[3:0]}, i[0] ? 8'h11 : 8'h18, per[i], i + 1);
    go(8'h0f, 8'h01, 2, 1);
    go(8'h0f, 8'h08, 2, 1);
    wr(`AST_IDX_IRQ_CLR, 8'h07);
    for (int k = 0; k < 24; k++) begin
      rnd = lfsr(rnd);
      p = k[0];
      en = rnd[2];
      hi = p ? {2'b0, rnd[15:10]} : {4'b0, rnd[15:12]};
      t = {hi[5:0], rnd[7:0]};
      r = t + {12'h0, rnd[9:8]} - 14'h1;
      if (!p) r[13:12] = rnd[11:10];
      over = p ? r > t : r[11:0] > t[11:0];
      nextResult <= r;
      wr(`AST_IDX_UPHI, hi);
      wr(`AST_IDX_UPLO, rnd[7:0]);
      wr(`AST_IDX_IRQ_EN, {7'h0, en});
      go(8'h00, {5'h0, p, 2'b01}, 2, 1);
      rd(`AST_IDX_STATUS, 8'h01, {7'h0, over});
      `CHK("irq", over & en, irq)
      wr(`AST_IDX_IRQ_CLR, 8'h03);
    end
    conclude();
  end
endmodule // ast_sample_timer_bench
`default_nettype wire
